// *** verilog/tpq_top.sv ***
// transmit command queues, head pointer readout and transmit buffer early release
// assumes byte writes, processing and transmit progress come from the engine
`timescale 1ns/1ps
`include "tpq_map.svh"
// How it works
// - two command queues, high and low; fetches serve high first, then low
// - pointer read returns address of next high queue block to process
// - no fetch in read cycle, so reported block stays unfetched and editable
// - transmit buffer holds 3072 bytes of frame data
// - early release only when enabled; otherwise space frees at transmit completion
// - only the oldest frame, at queue head, may be released early
// - released frame must be fully written and processed
// - frames over 3072 bytes never released early
// - more than 128 bytes must have entered the sync buffer
// - with preemption on, a frame not at head is never released
module tpq_top #(
  parameter int HQ_DEPTH = 8,
  parameter int LQ_DEPTH = 8,
  parameter int QAW      = 3,
  parameter int FRAMES   = 8,
  parameter int FAW      = 3
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   hp_push_valid,
  input  wire logic [`TPQ_ADDR_W-1:0] hp_push_addr,
  output logic                        hp_push_ready,
  input  wire logic                   lp_push_valid,
  input  wire logic [`TPQ_ADDR_W-1:0] lp_push_addr,
  output logic                        lp_push_ready,
  input  wire logic                   hp_edit_en,
  input  wire logic [QAW-1:0]         hp_edit_ofs,
  input  wire logic [`TPQ_ADDR_W-1:0] hp_edit_addr,
  input  wire logic                   ptr_rd,
  output logic                        ptr_rd_valid,
  output logic [`TPQ_ADDR_W-1:0]      ptr_rd_addr,
  input  wire logic                   fetch_ready,
  output logic                        fetch_valid,
  output tpq_pkg::tpq_fetch_t         fetch_cmd,
  input  wire logic                   early_rel_en,
  input  wire logic                   wr_valid,
  input  wire logic                   wr_last,
  output logic                        wr_ready,
  input  wire logic                   proc_done,
  input  wire logic                   tx_is_head,
  input  wire logic                   preempt_on,
  input  wire logic                   sync_byte,
  input  wire logic                   tx_done,
  output logic [`TPQ_FREE_W-1:0]      free_bytes,
  output logic                        early_rel,
  output logic                        head_released
);
  logic                   hp_valid;
  logic [`TPQ_ADDR_W-1:0] hp_head;
  logic                   lp_valid;
  logic [`TPQ_ADDR_W-1:0] lp_head;
  tpq_pkg::tpq_src_t      src;
  logic                   fetch_go;

  tpq_pkg::tpq_frame_t    ring [FRAMES];
  logic [FAW-1:0]         wr_ptr;
  logic [FAW-1:0]         rd_ptr;
  logic [FAW-1:0]         proc_ptr;
  logic [FAW:0]           cnt;
  logic [FAW:0]           unproc;
  logic [`TPQ_LEN_W-1:0]  cur_len;
  logic [`TPQ_LEN_W-1:0]  sync_cnt;
  logic                   wbyte;
  logic                   push_frm;
  logic                   pop_frm;
  logic                   mark_proc;
  tpq_pkg::tpq_frame_t    head_frm;
  logic                   rel_ok;
  logic [`TPQ_FREE_W-1:0] give_back;

  tpq_cmd_queue #(.DEPTH(HQ_DEPTH), .AW(QAW)) u_high_q (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .push_valid (hp_push_valid),
    .push_addr  (hp_push_addr),
    .push_ready (hp_push_ready),
    .pop        (fetch_go && (src == tpq_pkg::TPQ_SRC_HIGH)),
    .head_valid (hp_valid),
    .head_addr  (hp_head),
    .edit_en    (hp_edit_en),
    .edit_ofs   (hp_edit_ofs),
    .edit_addr  (hp_edit_addr)
  );

  tpq_cmd_queue #(.DEPTH(LQ_DEPTH), .AW(QAW)) u_low_q (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .push_valid (lp_push_valid),
    .push_addr  (lp_push_addr),
    .push_ready (lp_push_ready),
    .pop        (fetch_go && (src == tpq_pkg::TPQ_SRC_LOW)),
    .head_valid (lp_valid),
    .head_addr  (lp_head),
    .edit_en    (1'b0),
    .edit_ofs   ('0),
    .edit_addr  ('0)
  );

  // high queue always served before low
  always_comb begin
    case ({hp_valid, lp_valid})
      2'b10, 2'b11: src = tpq_pkg::TPQ_SRC_HIGH;
      2'b01:        src = tpq_pkg::TPQ_SRC_LOW;
      default:      src = tpq_pkg::TPQ_SRC_NONE;
    endcase
  end

  // fetch held off while software reads the pointer
  assign fetch_valid     = (src != tpq_pkg::TPQ_SRC_NONE) && !ptr_rd;
  assign fetch_go        = fetch_valid && fetch_ready;
  assign fetch_cmd.high  = (src == tpq_pkg::TPQ_SRC_HIGH);
  assign fetch_cmd.addr  = fetch_cmd.high ? hp_head : lp_head;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_rd_valid <= 1'b0;
      ptr_rd_addr  <= `TPQ_PTR_RST;
    end else begin
      ptr_rd_valid <= ptr_rd;
      if (ptr_rd) begin
        ptr_rd_addr <= hp_valid ? hp_head : `TPQ_PTR_RST;
      end
    end
  end

  // transmit buffer accounting, one entry per fully written frame
  assign wr_ready  = (free_bytes != '0) && (cnt != (FAW+1)'(FRAMES));
  assign wbyte     = wr_valid && wr_ready;
  assign push_frm  = wbyte && wr_last;
  assign pop_frm   = tx_done && (cnt != '0);
  assign mark_proc = proc_done && (unproc != '0);
  assign head_frm  = ring[rd_ptr];

  // qualification; the head entry is the oldest frame in the buffer
  assign rel_ok = early_rel_en
                && tx_is_head
                && (cnt != '0) && head_frm.proc
                && (head_frm.len <= `TPQ_LEN_W'(`TPQ_BUF_BYTES))
                && (sync_cnt > `TPQ_SLOT_BYTES)
                && !head_released && !tx_done;
  assign early_rel = rel_ok;

  // a released frame gives nothing back again at completion
  always_comb begin
    give_back = '0;
    if (rel_ok || (pop_frm && !head_released)) begin
      give_back = head_frm.len[`TPQ_FREE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      free_bytes <= `TPQ_BUF_BYTES;
    end else begin
      free_bytes <= free_bytes + give_back - `TPQ_FREE_W'(wbyte);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      head_released <= 1'b0;
      sync_cnt      <= '0;
    end else begin
      if (pop_frm) begin
        head_released <= 1'b0;
        sync_cnt      <= '0;
      end else begin
        if (rel_ok) begin
          head_released <= 1'b1;
        end
        // saturate; only the slot threshold matters
        if (sync_byte && (sync_cnt != '1)) begin
          sync_cnt <= sync_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      proc_ptr <= '0;
      cnt      <= '0;
      unproc   <= '0;
      cur_len  <= '0;
    end else begin
      if (wbyte) begin
        cur_len <= wr_last ? '0 : cur_len + 1'b1;
      end
      if (push_frm) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_frm) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (mark_proc) begin
        proc_ptr <= proc_ptr + 1'b1;
      end
      cnt    <= cnt + (FAW+1)'(push_frm) - (FAW+1)'(pop_frm);
      unproc <= unproc + (FAW+1)'(push_frm) - (FAW+1)'(mark_proc);
    end
  end

  // processing flag set after the entry write so a same-cycle mark is kept
  always_ff @(posedge sys_clk) begin
    if (push_frm) begin
      ring[wr_ptr].len  <= cur_len + 1'b1;
      ring[wr_ptr].proc <= 1'b0;
    end
    if (mark_proc) begin
      ring[proc_ptr].proc <= 1'b1;
    end
  end

  chk_high_first: assert property (@(posedge sys_clk) disable iff (rst)
    (hp_valid && fetch_go) |-> fetch_cmd.high && fetch_cmd.addr == hp_head)
    else $error("high queue not served first");
  chk_ptr_value: assert property (@(posedge sys_clk) disable iff (rst)
    (ptr_rd && hp_valid) |=> ptr_rd_valid && ptr_rd_addr == $past(hp_head))
    else $error("pointer read gave wrong address");
  chk_no_fetch_read: assert property (@(posedge sys_clk) disable iff (rst)
    ptr_rd |-> !fetch_go)
    else $error("fetch during pointer read");
  chk_free_cap: assert property (@(posedge sys_clk) disable iff (rst)
    free_bytes <= `TPQ_BUF_BYTES)
    else $error("free space above buffer size");
  chk_rel_enabled: assert property (@(posedge sys_clk) disable iff (rst)
    !early_rel_en |-> !early_rel)
    else $error("early release while disabled");
  chk_rel_oldest: assert property (@(posedge sys_clk) disable iff (rst)
    early_rel |-> tx_is_head && cnt != '0)
    else $error("release of frame not at head");
  chk_rel_processed: assert property (@(posedge sys_clk) disable iff (rst)
    early_rel |-> head_frm.proc)
    else $error("release before processing");
  chk_rel_length: assert property (@(posedge sys_clk) disable iff (rst)
    early_rel |-> head_frm.len <= 16'h0c00)
    else $error("release of oversized frame");
  chk_rel_slot: assert property (@(posedge sys_clk) disable iff (rst)
    early_rel |-> sync_cnt >= 16'h0081)
    else $error("release before slot time");
  chk_preempt_head: assert property (@(posedge sys_clk) disable iff (rst)
    (preempt_on && !tx_is_head) |-> !early_rel)
    else $error("release under preemption off head");
  chk_rel_frees: assert property (@(posedge sys_clk) disable iff (rst)
    early_rel |=> head_released && free_bytes ==
      $past(free_bytes) + $past(head_frm.len[12:0]) - 13'($past(wbyte)))
    else $error("release did not return space");
endmodule

// *** pkg/tpq_map.svh ***
// constants of the transmit priority queue and early release block
// assumes byte-wide writes into the transmit buffer memory
`ifndef TPQ_MAP_SVH
`define TPQ_MAP_SVH
`define TPQ_ADDR_W      32
`define TPQ_LEN_W       16
`define TPQ_FREE_W      13
`define TPQ_BUF_BYTES   13'h0c00
`define TPQ_SLOT_BYTES  16'h0080
`define TPQ_PTR_RST     32'h0000_0000
`endif

// *** pkg/tpq_pkg.sv ***
// types shared by the transmit priority queue block
// assumes tpq_map.svh is on the include path
`include "tpq_map.svh"
package tpq_pkg;
  typedef enum logic [1:0] {
    TPQ_SRC_NONE,
    TPQ_SRC_HIGH,
    TPQ_SRC_LOW
  } tpq_src_t;

  typedef struct packed {
    logic [`TPQ_ADDR_W-1:0] addr;
    logic                   high;
  } tpq_fetch_t;

  typedef struct packed {
    logic [`TPQ_LEN_W-1:0] len;
    logic                  proc;
  } tpq_frame_t;
endpackage

// *** verilog/tpq_cmd_queue.sv ***
// one queue of transmit command block addresses
// assumes a single clock; entries behind the head may be rewritten in place
`timescale 1ns/1ps
`include "tpq_map.svh"
module tpq_cmd_queue #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   push_valid,
  input  wire logic [`TPQ_ADDR_W-1:0] push_addr,
  output logic                        push_ready,
  input  wire logic                   pop,
  output logic                        head_valid,
  output logic [`TPQ_ADDR_W-1:0]      head_addr,
  input  wire logic                   edit_en,
  input  wire logic [AW-1:0]          edit_ofs,
  input  wire logic [`TPQ_ADDR_W-1:0] edit_addr
);
  logic [`TPQ_ADDR_W-1:0] mem [DEPTH];
  logic [AW-1:0]          rd_ptr;
  logic [AW-1:0]          wr_ptr;
  logic [AW:0]            count;
  logic                   do_push;
  logic                   do_pop;
  logic [AW-1:0]          edit_idx;

  assign push_ready = (count != (AW+1)'(DEPTH));
  assign head_valid = (count != '0);
  assign head_addr  = mem[rd_ptr];
  assign do_push    = push_valid && push_ready;
  assign do_pop     = pop && head_valid;
  assign edit_idx   = rd_ptr + edit_ofs;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // edits past the tail are dropped; a push wins a clash on the same slot
  always_ff @(posedge sys_clk) begin
    if (edit_en && ((AW+1)'(edit_ofs) < count)) begin
      mem[edit_idx] <= edit_addr;
    end
    if (do_push) begin
      mem[wr_ptr] <= push_addr;
    end
  end
endmodule

// *** sim/tpq_host_model.sv ***
// host side model: takes command block fetches, prompt or stalled, logs the last one
// assumes the bench drives stall just after the rising edge
`timescale 1ns/1ps
`include "tpq_map.svh"
module tpq_host_model (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   stall,
  input  wire logic                   fetch_valid,
  input  wire tpq_pkg::tpq_fetch_t    fetch_cmd,
  output logic                        fetch_ready,
  output logic [`TPQ_ADDR_W-1:0]      got_addr,
  output logic                        got_high
);
  // stalling keeps blocks unfetched so the bench can rewrite them in place
  assign fetch_ready = !stall;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      got_addr <= '0;
      got_high <= 1'b0;
    end else if (fetch_valid && fetch_ready) begin
      got_addr <= fetch_cmd.addr;
      got_high <= fetch_cmd.high;
    end
  end
endmodule

// *** sim/tx_priority_queue_early_release_tb_top.sv ***
// self-checking bench for the transmit queues and early release
// assumes the host model answers fetches; engine strobes come from here
`timescale 1ns/1ps
`include "tpq_map.svh"
module tx_priority_queue_early_release_tb_top;
  logic                   sys_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   hp_push_valid = 1'b0, lp_push_valid = 1'b0;
  logic [`TPQ_ADDR_W-1:0] hp_push_addr = '0, lp_push_addr = '0, hp_edit_addr = '0;
  logic                   hp_edit_en = 1'b0, ptr_rd = 1'b0, stall = 1'b1;
  logic [2:0]             hp_edit_ofs = '0;
  logic                   early_rel_en = 1'b0, wr_valid = 1'b0, wr_last = 1'b0;
  logic                   proc_done = 1'b0, tx_is_head = 1'b0, preempt_on = 1'b0;
  logic                   sync_byte = 1'b0, tx_done = 1'b0;
  logic                   hp_push_ready, lp_push_ready, ptr_rd_valid, fetch_ready;
  logic                   fetch_valid, wr_ready, early_rel, head_released, got_high;
  logic [`TPQ_ADDR_W-1:0] ptr_rd_addr, got_addr;
  logic [`TPQ_FREE_W-1:0] free_bytes;
  tpq_pkg::tpq_fetch_t    fetch_cmd;
  int                     failures = 0;
  int                     checked = 0;

  initial forever #12.5 sys_clk = ~sys_clk;

  tpq_top dut (.sys_clk(sys_clk), .rst(rst), .hp_push_valid(hp_push_valid),
    .hp_push_addr(hp_push_addr), .hp_push_ready(hp_push_ready),
    .lp_push_valid(lp_push_valid), .lp_push_addr(lp_push_addr),
    .lp_push_ready(lp_push_ready), .hp_edit_en(hp_edit_en), .hp_edit_ofs(hp_edit_ofs),
    .hp_edit_addr(hp_edit_addr), .ptr_rd(ptr_rd), .ptr_rd_valid(ptr_rd_valid),
    .ptr_rd_addr(ptr_rd_addr), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_cmd(fetch_cmd), .early_rel_en(early_rel_en), .wr_valid(wr_valid),
    .wr_last(wr_last), .wr_ready(wr_ready), .proc_done(proc_done),
    .tx_is_head(tx_is_head), .preempt_on(preempt_on), .sync_byte(sync_byte),
    .tx_done(tx_done), .free_bytes(free_bytes), .early_rel(early_rel),
    .head_released(head_released));

  tpq_host_model host (.sys_clk(sys_clk), .rst(rst), .stall(stall),
    .fetch_valid(fetch_valid), .fetch_cmd(fetch_cmd), .fetch_ready(fetch_ready),
    .got_addr(got_addr), .got_high(got_high));

  task automatic step();
    @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one fetch let through, then the host stalls again
  task automatic fetch_one(input logic [`TPQ_ADDR_W-1:0] a, input logic h);
    stall = 1'b0;
    step();
    stall = 1'b1;
    chk(got_addr === a && got_high === h, "wrong fetched block");
    step();
  endtask

  task automatic write_frame(input int len);
    for (int i = 0; i < len; i++) begin
      wr_valid = 1'b1;
      wr_last = (i == len - 1);
      while (wr_ready !== 1'b1) step();
      step();
    end
    wr_valid = 1'b0;
    wr_last = 1'b0;
  endtask

  task automatic pulse_proc();
    proc_done = 1'b1;
    step();
    proc_done = 1'b0;
  endtask

  // n sync bytes, then two cycles for a release to land
  task automatic sync_bytes(input int n);
    for (int i = 0; i < n; i++) begin
      sync_byte = 1'b1;
      step();
    end
    sync_byte = 1'b0;
    step();
    step();
  endtask

  task automatic pulse_tx_done();
    tx_done = 1'b1;
    step();
    tx_done = 1'b0;
    step();
  endtask

  task automatic t_priority();
    lp_push_valid = 1'b1;
    lp_push_addr = 32'h0000_1000;
    hp_push_valid = 1'b1;
    hp_push_addr = 32'h0000_2000;
    step();
    lp_push_valid = 1'b0;
    hp_push_valid = 1'b0;
    fetch_one(32'h0000_2000, 1'b1);
    fetch_one(32'h0000_1000, 1'b0);
  endtask

  task automatic t_pointer();
    hp_push_valid = 1'b1;
    hp_push_addr = 32'h0000_3000;
    step();
    hp_push_addr = 32'h0000_3040;
    step();
    hp_push_valid = 1'b0;
    ptr_rd = 1'b1;
    stall = 1'b0;
    #1;
    chk(fetch_valid === 1'b0, "fetch during pointer read");
    step();
    ptr_rd = 1'b0;
    stall = 1'b1;
    chk(ptr_rd_valid === 1'b1 && ptr_rd_addr === 32'h0000_3000, "pointer");
    // the reported block and the one behind it are both rewritten
    hp_edit_en = 1'b1;
    hp_edit_ofs = 3'h1;
    hp_edit_addr = 32'h0000_3080;
    step();
    hp_edit_ofs = 3'h0;
    hp_edit_addr = 32'h0000_30c0;
    step();
    hp_edit_en = 1'b0;
    fetch_one(32'h0000_30c0, 1'b1);
    fetch_one(32'h0000_3080, 1'b1);
  endtask

  // nine pushes into eight entries; the ninth must be refused
  task automatic t_queue_full();
    hp_push_valid = 1'b1;
    for (int i = 0; i < 9; i++) begin
      hp_push_addr = 32'h0000_4000 + 32'(i);
      step();
    end
    hp_push_valid = 1'b0;
    chk(hp_push_ready === 1'b0 && lp_push_ready === 1'b1, "queue full flag");
    for (int i = 0; i < 8; i++) begin
      fetch_one(32'h0000_4000 + 32'(i), 1'b1);
    end
    chk(fetch_valid === 1'b0, "ninth push not refused");
    ptr_rd = 1'b1;
    step();
    ptr_rd = 1'b0;
    chk(ptr_rd_valid === 1'b1 && ptr_rd_addr === `TPQ_PTR_RST, "empty pointer");
  endtask

  task automatic t_release_off();
    tx_is_head = 1'b1;
    write_frame(200);
    chk(free_bytes === `TPQ_BUF_BYTES - 13'h00c8, "free after write");
    pulse_proc();
    sync_bytes(129);
    chk(head_released === 1'b0, "release while disabled");
    pulse_tx_done();
    chk(free_bytes === `TPQ_BUF_BYTES, "free after completion");
  endtask

  task automatic t_release_on();
    early_rel_en = 1'b1;
    preempt_on = 1'b1;
    write_frame(200);
    pulse_proc();
    sync_bytes(128);
    chk(head_released === 1'b0, "release at 128 bytes");
    tx_is_head = 1'b0;
    sync_bytes(1);
    chk(head_released === 1'b0, "release of non head frame");
    tx_is_head = 1'b1;
    #1;
    chk(early_rel === 1'b1, "no release pulse");
    step();
    step();
    chk(head_released === 1'b1 && free_bytes === `TPQ_BUF_BYTES, "release");
    chk(early_rel === 1'b0, "second release of one frame");
    write_frame(100);
    chk(free_bytes === `TPQ_BUF_BYTES - 13'h0064, "reuse freed space");
    pulse_tx_done();
    chk(free_bytes === `TPQ_BUF_BYTES - 13'h0064, "double free");
    sync_bytes(129);
    chk(head_released === 1'b0, "release before processing");
    pulse_proc();
    chk(early_rel === 1'b1, "no late release pulse");
    step();
    chk(head_released === 1'b1 && free_bytes === `TPQ_BUF_BYTES, "late release");
    pulse_tx_done();
  endtask

  // frames over the buffer size cannot be written whole; the design guards that
  initial begin
    repeat (4) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    chk(free_bytes === `TPQ_BUF_BYTES && fetch_valid === 1'b0, "reset");
    chk(hp_push_ready === 1'b1 && lp_push_ready === 1'b1, "queues after reset");
    chk(wr_ready === 1'b1 && head_released === 1'b0, "buffer after reset");
    t_priority();
    t_pointer();
    t_queue_full();
    t_release_off();
    t_release_on();
    finish_test();
  end

  initial begin
    #(25 * 5000);
    failures++;
    finish_test();
  end
endmodule
